// ==== verilog/wdt_pkg.sv ====
// Purpose: shared constants, types and decode for the watchdog timer
// Assumes: 50 MHz system clock, 31 kHz low-frequency oscillator sampled as a pin
// Notes:   register offsets are word indices on the plain register port
package wdt_pkg;

	// time base
	localparam int unsigned SYS_CLK_HZ        = 50_000_000;
	localparam int unsigned LFO_FREQ_HZ       = 31_000;
	localparam int unsigned MIN_TIMEOUT_MS    = 1;
	localparam int unsigned MAX_TIMEOUT_S     = 256;
	localparam int unsigned DEFAULT_TIMEOUT_S = 2;
	// system clocks per oscillator period, not used by the design, coverage or bench
	localparam int unsigned LFO_PERIOD_CYCLES = SYS_CLK_HZ / LFO_FREQ_HZ;

	// widths
	localparam int CNT_W    = 24;
	localparam int PERIOD_W = 5;
	localparam int ADDR_W   = 4;
	localparam int DATA_W   = 8;
	localparam int IRQ_W    = 2;

	typedef logic [CNT_W-1:0]    count_t;
	typedef logic [PERIOD_W-1:0] period_t;
	typedef logic [ADDR_W-1:0]   addr_t;
	typedef logic [DATA_W-1:0]   data_t;
	typedef logic [IRQ_W-1:0]    irq_t;

	typedef enum logic [1:0]
	{
		MODE_OFF        = 2'b00,
		MODE_SOFTWARE   = 2'b01,
		MODE_AWAKE_ONLY = 2'b10,
		MODE_ALWAYS     = 2'b11
	} wdt_mode_t;

	// register indices
	localparam addr_t ADDR_CONTROL    = 4'h0;
	localparam addr_t ADDR_IRQ_STATUS = 4'h1;
	localparam addr_t ADDR_IRQ_CLEAR  = 4'h2;
	localparam addr_t ADDR_IRQ_ENABLE = 4'h3;
	localparam addr_t ADDR_STATE      = 4'h4;

	// control layout
	localparam int CTRL_SWEN_BIT   = 0;
	localparam int CTRL_PERIOD_LSB = 1;
	localparam int CTRL_PERIOD_MSB = 5;

	// interrupt layout
	localparam int IRQ_RESET_BIT = 0;
	localparam int IRQ_WAKE_BIT  = 1;

	// state register layout
	localparam int STATE_ACTIVE_BIT = 0;
	localparam int STATE_SLEEP_BIT  = 1;
	localparam int STATE_TMO_N_BIT   = 2;
	localparam int STATE_PWRDN_N_BIT = 3;

	// reset values
	localparam period_t PERIOD_RESET   = 5'h0b;
	localparam logic    SWEN_RESET     = 1'b0;
	localparam irq_t    IRQ_NONE       = 2'h0;
	localparam data_t   DATA_ZERO      = 8'h00;
	localparam count_t  COUNT_ZERO     = 24'h000000;
	localparam count_t  COUNT_ONE      = 24'h000001;

	// prescale decode
	localparam period_t PERIOD_MAX_CODE = 5'h12;
	localparam count_t  RATIO_MIN       = 24'h000020;
	localparam count_t  RATIO_MAX       = 24'h800000;

	// reserved codes fall back to the shortest interval
	function automatic count_t period_ratio(input period_t p);
		if (p > PERIOD_MAX_CODE)
		begin
			return RATIO_MIN;
		end
		return RATIO_MIN << p;
	endfunction

endpackage

// ==== verilog/wdt_cnt_if.sv ====
// Purpose: link between the watchdog control logic and its prescaled counter
// Assumes: both ends run on the system clock
// Notes:   expired is a one-cycle pulse
`timescale 1ns/1ps
interface wdt_cnt_if;
	import wdt_pkg::*;

	logic    tick;
	logic    clear;
	period_t period;
	count_t  count;
	logic    expired;

	modport ctrl
	(
		output tick,
		output clear,
		output period,
		input  count,
		input  expired
	);

	modport counter
	(
		input  tick,
		input  clear,
		input  period,
		output count,
		output expired
	);
endinterface

// ==== verilog/wdt_prescale_counter.sv ====
// Purpose: prescaled watchdog count advanced by oscillator ticks
// Assumes: tick is a one-cycle pulse per oscillator period
// Notes:   clear beats tick; the count restarts after expiry
`timescale 1ns/1ps
module wdt_prescale_counter
(
	input  wire logic   i_mclk,
	input  wire logic   i_rst_n,
	wdt_cnt_if.counter  cnt
);
	import wdt_pkg::*;

	count_t count_reg;
	count_t count_next;
	count_t ratio;
	logic   expired;

	always_comb
	begin
		ratio      = period_ratio(cnt.period);
		expired    = cnt.tick && !cnt.clear && (count_reg == ratio - COUNT_ONE);
		count_next = count_reg;
		if (cnt.clear || expired)
		begin
			count_next = COUNT_ZERO;
		end
		else if (cnt.tick)
		begin
			// only oscillator ticks advance the count
			count_next = count_reg + COUNT_ONE;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			count_reg <= COUNT_ZERO;
		end
		else
		begin
			count_reg <= count_next;
		end
	end

	assign cnt.count   = count_reg;
	assign cnt.expired = expired;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	a_tick_only_advance: assert property (!cnt.tick && !cnt.clear |=> count_reg == $past(count_reg))
		else $error("count moved without an oscillator tick");
	a_expire_restart: assert property (expired |=> count_reg == COUNT_ZERO)
		else $error("count did not restart after expiry");
	a_reserved_ratio: assert property (cnt.period > PERIOD_MAX_CODE |-> ratio == RATIO_MIN)
		else $error("reserved period code not at shortest ratio");
	a_ratio_range: assert property (ratio >= RATIO_MIN && ratio <= RATIO_MAX)
		else $error("ratio outside documented range");
	a_expire_point: assert property (cnt.tick && !cnt.clear && count_reg == ratio - COUNT_ONE |-> expired)
		else $error("expiry missed at the selected ratio");
endmodule

// ==== verilog/watchdog_timer.sv ====
// Purpose: watchdog timer with four operating modes and sleep handling
// Assumes: i_lfo is the free-running low-frequency oscillator; other inputs are system-clock pulses/levels
// Notes:   registers on a plain port, read data one cycle after the read strobe
//
// Function
// - request a device reset when the count reaches the time-out without a clear
// - count only on ticks of the 31 kHz low-frequency oscillator
// - mode 11: always active, sleep included, software bit ignored
// - mode 10: active while awake, disabled in sleep
// - mode 01: software bit alone decides, sleep does not matter
// - mode 00: always disabled, software bit ignored
// - period field spans 1 ms up to 256 s nominal
// - any reset returns the period field to the two second value
// - reset and the clear instruction clear count and prescaler
// - clear on sleep entry and again on interrupt wake-up
// - held clear while the oscillator start-up timer runs
// - clear on oscillator failure or clock switch; a period field write does not clear the count
// - held clear while the watchdog is disabled
// - code 00000 is 1:32, doubling to 2^23 at 10010; reserved codes 1:32
// - time-out in sleep wakes the device and updates the status flags
// - in software mode the enable bit turns the watchdog on or off
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module watchdog_timer
(
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	input  wire logic              i_lfo,
	input  wire wdt_pkg::wdt_mode_t i_mode_cfg,
	input  wire logic              i_sleep,
	input  wire logic              i_wake_irq,
	input  wire logic              i_clr_wdt,
	input  wire logic              i_osc_fail,
	input  wire logic              i_clk_switch,
	input  wire logic              i_startup_running,
	input  wire wdt_pkg::addr_t    i_addr,
	input  wire wdt_pkg::data_t    i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output wdt_pkg::data_t         o_rdata,
	output logic                   o_reset_req,
	output logic                   o_wake_req,
	output logic                   o_timeout_flag_n,
	output logic                   o_powerdown_flag_n,
	output logic                   o_irq
);
	import wdt_pkg::*;

	wdt_cnt_if cnt_if ();

	wdt_prescale_counter wdt_prescale_counter_inst
	(
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.cnt     (cnt_if.counter)
	);

	// oscillator synchroniser: three stages, level taken once stages two and three agree
	logic lfo_meta_reg;
	logic lfo_mid_reg;
	logic lfo_late_reg;
	logic lfo_level_reg;
	logic lfo_level_next;
	logic lfo_tick;

	always_comb
	begin
		lfo_level_next = lfo_level_reg;
		if (lfo_mid_reg == lfo_late_reg)
		begin
			lfo_level_next = lfo_late_reg;
		end
		lfo_tick = !lfo_level_reg && lfo_level_next;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			lfo_meta_reg  <= 1'b0;
			lfo_mid_reg   <= 1'b0;
			lfo_late_reg  <= 1'b0;
			lfo_level_reg <= 1'b0;
		end
		else
		begin
			lfo_meta_reg  <= i_lfo;
			lfo_mid_reg   <= lfo_meta_reg;
			lfo_late_reg  <= lfo_mid_reg;
			lfo_level_reg <= lfo_level_next;
		end
	end

	// control register
	period_t period_reg;
	period_t period_next;
	logic    swen_reg;
	logic    swen_next;
	logic    ctrl_wr;

	always_comb
	begin
		ctrl_wr     = i_wr && (i_addr == ADDR_CONTROL);
		period_next = period_reg;
		swen_next   = swen_reg;
		if (ctrl_wr)
		begin
			period_next = i_wdata[CTRL_PERIOD_MSB:CTRL_PERIOD_LSB];
			swen_next   = i_wdata[CTRL_SWEN_BIT];
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			period_reg <= PERIOD_RESET;
			swen_reg   <= SWEN_RESET;
		end
		else
		begin
			period_reg <= period_next;
			swen_reg   <= swen_next;
		end
	end

	// operating mode
	logic active;

	always_comb
	begin
		unique case (i_mode_cfg)
			MODE_ALWAYS:     active = 1'b1;
			MODE_AWAKE_ONLY: active = !i_sleep;
			MODE_SOFTWARE:   active = swen_reg;
			MODE_OFF:        active = 1'b0;
		endcase
	end

	// clear sources; all are system-clock signals, so no crossing is needed here
	logic sleep_d_reg;
	logic sleep_enter;
	logic sleep_exit;
	logic cnt_clear;

	always_comb
	begin
		sleep_enter = i_sleep && !sleep_d_reg;
		sleep_exit  = !i_sleep && sleep_d_reg;
		cnt_clear   = i_clr_wdt
		            || sleep_enter || sleep_exit || i_wake_irq
		            || i_startup_running
		            || i_osc_fail || i_clk_switch
		            || !active;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			sleep_d_reg <= 1'b0;
		end
		else
		begin
			sleep_d_reg <= i_sleep;
		end
	end

	assign cnt_if.tick   = lfo_tick;
	assign cnt_if.clear  = cnt_clear;
	assign cnt_if.period = period_reg;

	// time-out outcome and status flags
	logic reset_req_reg;
	logic reset_req_next;
	logic wake_req_reg;
	logic wake_req_next;
	logic tmo_n_reg;
	logic tmo_n_next;
	logic pwrdn_n_reg;
	logic pwrdn_n_next;
	logic timeout;

	always_comb
	begin
		timeout        = cnt_if.expired && active;
		// a registered single pulse, never a level that could repeat
		reset_req_next = timeout && !i_sleep;
		wake_req_next  = timeout && i_sleep;
		tmo_n_next     = tmo_n_reg;
		pwrdn_n_next   = pwrdn_n_reg;
		if (timeout)
		begin
			tmo_n_next   = 1'b0;
			pwrdn_n_next = i_sleep ? 1'b0 : pwrdn_n_reg;
		end
		else if (sleep_enter)
		begin
			tmo_n_next   = 1'b1;
			pwrdn_n_next = 1'b0;
		end
		else if (i_clr_wdt)
		begin
			tmo_n_next   = 1'b1;
			pwrdn_n_next = 1'b1;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			reset_req_reg <= 1'b0;
			wake_req_reg  <= 1'b0;
			tmo_n_reg     <= 1'b1;
			pwrdn_n_reg   <= 1'b1;
		end
		else
		begin
			reset_req_reg <= reset_req_next;
			wake_req_reg  <= wake_req_next;
			tmo_n_reg     <= tmo_n_next;
			pwrdn_n_reg   <= pwrdn_n_next;
		end
	end

	// interrupt status: set beats a clear in the same cycle
	irq_t irq_status_reg;
	irq_t irq_status_next;
	irq_t irq_enable_reg;
	irq_t irq_enable_next;
	irq_t irq_events;
	irq_t irq_clear_mask;

	always_comb
	begin
		irq_events                = IRQ_NONE;
		irq_events[IRQ_RESET_BIT] = reset_req_next;
		irq_events[IRQ_WAKE_BIT]  = wake_req_next;
		irq_clear_mask            = IRQ_NONE;
		if (i_wr && (i_addr == ADDR_IRQ_CLEAR))
		begin
			irq_clear_mask = i_wdata[IRQ_W-1:0];
		end
		irq_status_next = (irq_status_reg & ~irq_clear_mask) | irq_events;
		irq_enable_next = irq_enable_reg;
		if (i_wr && (i_addr == ADDR_IRQ_ENABLE))
		begin
			irq_enable_next = i_wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			irq_status_reg <= IRQ_NONE;
			irq_enable_reg <= IRQ_NONE;
		end
		else
		begin
			irq_status_reg <= irq_status_next;
			irq_enable_reg <= irq_enable_next;
		end
	end

	// read port; unmapped and write-only offsets read zero
	data_t rdata_reg;
	data_t rdata_next;

	always_comb
	begin
		rdata_next = DATA_ZERO;
		if (i_rd)
		begin
			unique case (i_addr)
				ADDR_CONTROL:    rdata_next = data_t'({period_reg, swen_reg});
				ADDR_IRQ_STATUS: rdata_next = data_t'(irq_status_reg);
				ADDR_IRQ_ENABLE: rdata_next = data_t'(irq_enable_reg);
				ADDR_STATE:
				begin
					rdata_next[STATE_ACTIVE_BIT] = active;
					rdata_next[STATE_SLEEP_BIT]  = i_sleep;
					rdata_next[STATE_TMO_N_BIT]   = tmo_n_reg;
					rdata_next[STATE_PWRDN_N_BIT] = pwrdn_n_reg;
				end
				default:         rdata_next = DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			rdata_reg <= DATA_ZERO;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_rdata            = rdata_reg;
	assign o_reset_req        = reset_req_reg;
	assign o_wake_req         = wake_req_reg;
	assign o_timeout_flag_n   = tmo_n_reg;
	assign o_powerdown_flag_n = pwrdn_n_reg;
	assign o_irq              = |(irq_status_reg & irq_enable_reg);

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	a_timeout_reset: assert property (cnt_if.expired && active && !i_sleep |=> o_reset_req && !o_wake_req)
		else $error("awake time-out gave no reset request");
	a_always_on: assert property (i_mode_cfg == MODE_ALWAYS |-> active)
		else $error("always-on mode not active");
	a_sleep_off: assert property (i_mode_cfg == MODE_AWAKE_ONLY |-> active == !i_sleep)
		else $error("awake-only mode wrong against sleep");
	a_software_mode: assert property (i_mode_cfg == MODE_SOFTWARE |-> active == swen_reg)
		else $error("software mode not following enable bit");
	a_always_off: assert property (i_mode_cfg == MODE_OFF |-> !active)
		else $error("off mode is active");
	a_period_reset: assert property (i_rst_n && !$past(i_rst_n) |-> period_reg == PERIOD_RESET)
		else $error("period not at two second value after reset");
	a_clear_cmd: assert property (i_clr_wdt |=> cnt_if.count == COUNT_ZERO)
		else $error("clear instruction did not clear count");
	a_sleep_clear: assert property (sleep_enter || i_wake_irq |=> cnt_if.count == COUNT_ZERO)
		else $error("sleep entry or wake did not clear count");
	a_startup_hold: assert property (i_startup_running |=> cnt_if.count == COUNT_ZERO)
		else $error("count moved while start-up timer runs");
	a_osc_clear: assert property (i_osc_fail || i_clk_switch |=> cnt_if.count == COUNT_ZERO)
		else $error("clock event did not clear count");
	a_disabled_hold: assert property (!active |=> cnt_if.count == COUNT_ZERO)
		else $error("count not held while disabled");
	a_sleep_wake: assert property (cnt_if.expired && active && i_sleep |=> o_wake_req && !o_reset_req && !o_timeout_flag_n && !o_powerdown_flag_n)
		else $error("sleep time-out did not wake with flags");
	a_swen_write: assert property (ctrl_wr |=> swen_reg == $past(i_wdata[CTRL_SWEN_BIT]))
		else $error("enable bit write lost");
	a_pulse_single: assert property (o_reset_req |=> !o_reset_req)
		else $error("reset request longer than one cycle");

	c_reset_request: cover property (o_reset_req);
	c_sleep_wake: cover property (o_wake_req);
	c_software_run: cover property (i_mode_cfg == MODE_SOFTWARE && swen_reg && lfo_tick);
	c_clear_race: cover property (o_irq ##1 i_wr && i_addr == ADDR_IRQ_CLEAR);
endmodule

// ==== test/tb_watchdog_timer.sv ====
// Purpose: self-checking bench for the watchdog timer top module
// Assumes: oscillator ticks are made as slow 8+8 cycle square pulses on i_lfo
// Notes:   pulse outputs are counted cycle by cycle, so a stuck pulse shows as a count above one
`timescale 1ns/1ps
module tb_watchdog_timer;
	import wdt_pkg::*;

	logic      i_mclk;
	logic      i_rst_n;
	logic      i_lfo;
	wdt_mode_t i_mode_cfg;
	logic      i_sleep;
	logic      i_wake_irq;
	logic      i_clr_wdt;
	logic      i_osc_fail;
	logic      i_clk_switch;
	logic      i_startup_running;
	addr_t     i_addr;
	data_t     i_wdata;
	logic      i_wr;
	logic      i_rd;
	data_t     o_rdata;
	logic      o_reset_req;
	logic      o_wake_req;
	logic      o_timeout_flag_n;
	logic      o_powerdown_flag_n;
	logic      o_irq;
	int        fail_count;
	int        compares;
	int        rst_cyc;
	int        wake_cyc;

	watchdog_timer watchdog_timer_inst
	(
		.i_mclk             (i_mclk),
		.i_rst_n            (i_rst_n),
		.i_lfo              (i_lfo),
		.i_mode_cfg         (i_mode_cfg),
		.i_sleep            (i_sleep),
		.i_wake_irq         (i_wake_irq),
		.i_clr_wdt          (i_clr_wdt),
		.i_osc_fail         (i_osc_fail),
		.i_clk_switch       (i_clk_switch),
		.i_startup_running  (i_startup_running),
		.i_addr             (i_addr),
		.i_wdata            (i_wdata),
		.i_wr               (i_wr),
		.i_rd               (i_rd),
		.o_rdata            (o_rdata),
		.o_reset_req        (o_reset_req),
		.o_wake_req         (o_wake_req),
		.o_timeout_flag_n   (o_timeout_flag_n),
		.o_powerdown_flag_n (o_powerdown_flag_n),
		.o_irq              (o_irq)
	);

	initial
	begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	// every high cycle counts, so a pulse longer than one cycle is caught
	always @(posedge i_mclk)
	begin
		if (o_reset_req === 1'b1)
			rst_cyc++;
		if (o_wake_req === 1'b1)
			wake_cyc++;
	end

	task automatic wrap_up();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input addr_t a, input data_t d);
		@(posedge i_mclk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr    <= 1'b0;
	endtask

	task automatic rd_chk(input string name, input addr_t a, input data_t exp);
		@(posedge i_mclk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd   <= 1'b0;
		#1;
		chk(name, exp, o_rdata);
	endtask

	task automatic set_ctrl(input period_t p, input logic s);
		wr(ADDR_CONTROL, {2'b00, p, s});
	endtask

	// one-cycle pulse on a clear source: 0 clear instr, 1 osc fail, 2 clock switch, 3 start-up timer, 4 wake irq
	task automatic pulse_src(input int k);
		@(posedge i_mclk);
		case (k)
			0: i_clr_wdt     <= 1'b1;
			1: i_osc_fail    <= 1'b1;
			2: i_clk_switch  <= 1'b1;
			3: i_startup_running <= 1'b1;
			default: i_wake_irq <= 1'b1;
		endcase
		@(posedge i_mclk);
		{i_clr_wdt, i_osc_fail, i_clk_switch, i_startup_running, i_wake_irq} <= 5'h00;
	endtask

	// n oscillator periods, then the pulse counts are judged
	task automatic run(input int n, input logic er, input logic ew);
		int r0;
		int w0;
		r0 = rst_cyc;
		w0 = wake_cyc;
		repeat (n)
		begin
			i_lfo <= 1'b1;
			repeat (8) @(posedge i_mclk);
			i_lfo <= 1'b0;
			repeat (8) @(posedge i_mclk);
		end
		repeat (6) @(posedge i_mclk);
		chk("reset pulse cycles", {7'h00, er}, 8'(rst_cyc - r0));
		chk("wake pulse cycles", {7'h00, ew}, 8'(wake_cyc - w0));
	endtask

	task automatic t_reset();
		rd_chk("control after reset", ADDR_CONTROL, 8'h16);
		rd_chk("irq status after reset", ADDR_IRQ_STATUS, 8'h00);
		rd_chk("irq enable after reset", ADDR_IRQ_ENABLE, 8'h00);
		rd_chk("unmapped read", 4'hf, 8'h00);
		chk("timeout flag after reset", 8'h01, {7'h00, o_timeout_flag_n});
	endtask

	// every mode, enable bit and sleep state; 31 ticks silent, the 32nd fires if active
	task automatic t_modes();
		logic act;
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 2; s++)
				for (int sl = 0; sl < 2; sl++)
				begin
					i_mode_cfg <= wdt_mode_t'(m[1:0]);
					set_ctrl(5'h00, s[0]);
					i_sleep <= sl[0];
					pulse_src(0);
					act = (m == 3) || (m == 2 && sl == 0) || (m == 1 && s == 1);
					run(31, 1'b0, 1'b0);
					run(1, act && sl == 0, act && sl == 1);
					i_sleep <= 1'b0;
					@(posedge i_mclk);
				end
	endtask

	task automatic t_clears();
		i_mode_cfg <= MODE_ALWAYS;
		set_ctrl(5'h00, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			pulse_src(0);
			run(20, 1'b0, 1'b0);
			pulse_src(k);
			run(31, 1'b0, 1'b0);
			run(1, 1'b1, 1'b0);
		end
		chk("timeout flag after awake expiry", 8'h00, {7'h00, o_timeout_flag_n});
	endtask

	task automatic t_sleep();
		pulse_src(0);
		run(20, 1'b0, 1'b0);
		i_sleep <= 1'b1;
		run(20, 1'b0, 1'b0);
		pulse_src(4);
		run(31, 1'b0, 1'b0);
		chk("powerdown flag in sleep", 8'h00, {7'h00, o_powerdown_flag_n});
		run(1, 1'b0, 1'b1);
		chk("timeout flag after wake", 8'h00, {7'h00, o_timeout_flag_n});
		chk("powerdown flag after wake", 8'h00, {7'h00, o_powerdown_flag_n});
		rd_chk("state after sleep wake", ADDR_STATE, 8'h03);
		i_sleep <= 1'b0;
		pulse_src(0);
		// flags update on the edge that ends the pulse; look once they have settled
		#1;
		chk("timeout flag after clear", 8'h01, {7'h00, o_timeout_flag_n});
		chk("powerdown flag after clear", 8'h01, {7'h00, o_powerdown_flag_n});
	endtask

	task automatic t_period();
		set_ctrl(5'h01, 1'b0);
		pulse_src(0);
		run(63, 1'b0, 1'b0);
		run(1, 1'b1, 1'b0);
		set_ctrl(5'h13, 1'b0);
		pulse_src(0);
		run(31, 1'b0, 1'b0);
		run(1, 1'b1, 1'b0);
		rd_chk("control readback", ADDR_CONTROL, 8'h26);
	endtask

	// reset in mid-run: count, control and status return to their reset values
	task automatic t_midreset();
		set_ctrl(5'h00, 1'b0);
		pulse_src(0);
		run(20, 1'b0, 1'b0);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rd_chk("control after mid-run reset", ADDR_CONTROL, 8'h16);
		rd_chk("irq status after mid-run reset", ADDR_IRQ_STATUS, 8'h00);
		set_ctrl(5'h00, 1'b0);
		run(31, 1'b0, 1'b0);
		run(1, 1'b1, 1'b0);
	endtask

	// status sticks, enable gates the line, clear write drops it
	task automatic t_irq();
		wr(ADDR_IRQ_CLEAR, 8'h03);
		wr(ADDR_IRQ_ENABLE, 8'h01);
		rd_chk("irq enable readback", ADDR_IRQ_ENABLE, 8'h01);
		set_ctrl(5'h00, 1'b0);
		pulse_src(0);
		run(32, 1'b1, 1'b0);
		rd_chk("irq status after expiry", ADDR_IRQ_STATUS, 8'h01);
		chk("irq line enabled", 8'h01, {7'h00, o_irq});
		wr(ADDR_IRQ_ENABLE, 8'h02);
		@(posedge i_mclk);
		chk("irq line masked", 8'h00, {7'h00, o_irq});
		wr(ADDR_IRQ_ENABLE, 8'h01);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		@(posedge i_mclk);
		chk("irq line cleared", 8'h00, {7'h00, o_irq});
		rd_chk("irq status cleared", ADDR_IRQ_STATUS, 8'h00);
	endtask

	// a hang is cut short here and counted
	initial
	begin
		repeat (100000) @(posedge i_mclk);
		fail_count++;
		wrap_up();
	end

	initial
	begin
		fail_count = 0;
		compares = 0;
		rst_cyc = 0;
		wake_cyc = 0;
		i_rst_n = 1'b0;
		i_lfo = 1'b0;
		i_mode_cfg = MODE_OFF;
		{i_sleep, i_wake_irq, i_clr_wdt, i_osc_fail, i_clk_switch, i_startup_running} = 6'h00;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (20) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_reset();
		t_modes();
		t_clears();
		t_sleep();
		t_period();
		t_midreset();
		t_irq();
		wrap_up();
	end
endmodule
